// ===== src/eeprom_autoload_params.svh
/*
 * Constants of the configuration autoloader: register map, EEPROM layout,
 * stop offsets and two-wire timing.
 * Assumes inclusion by bare name from the loader.
 */
`ifndef EEPROM_AUTOLOAD_PARAMS_SVH
`define EEPROM_AUTOLOAD_PARAMS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define AL_CLK_PERIOD_NS  20
`define AL_SCL_PERIOD_NS  10000
`define AL_QUARTERS       4

// ----------------------------------------------------------------
// EEPROM layout
// ----------------------------------------------------------------
`define AL_EE_DEV_WR      8'hA0
`define AL_EE_DEV_RD      8'hA1
`define AL_EE_FIRST       8'h00
`define AL_SIG_LO_ADDR    8'h00
`define AL_SIG_HI_ADDR    8'h01
`define AL_REGION_ADDR    8'h02
`define AL_MISC_ADDR      8'h03
`define AL_EE_LAST        8'hFF
`define AL_SIGNATURE      16'h1516
`define AL_REGION_FIELD   4:1
`define AL_MISC_WP_BIT    0
`define AL_REGION_G1      4'h0
`define AL_REGION_G2      4'h1
`define AL_REGION_G3      4'h3
`define AL_REGION_G4      4'h7
`define AL_STOP_G1        8'h0B
`define AL_STOP_G2        8'h67
`define AL_STOP_G3_DEF    8'h9A
`define AL_STOP_G4        8'hD7

// ----------------------------------------------------------------
// Byte map: {first EEPROM byte, last EEPROM byte, first cfg offset}
// ----------------------------------------------------------------
`define AL_MAP_N          64
`define AL_MAP_LO         27:20
`define AL_MAP_HI         19:12
`define AL_MAP_CFG        11:0
`define AL_MAP_TABLE '{ \
	28'h0405_000, 28'h0607_002, 28'h0808_008, 28'h0909_009, \
	28'h0A0B_00A, 28'h0C0C_034, 28'h0D0E_040, 28'h0F10_042, \
	28'h1114_048, 28'h1518_068, 28'h191A_081, 28'h1B1B_108, \
	28'h1C1E_091, 28'h1F21_0A1, 28'h2225_0A4, 28'h2629_0A8, \
	28'h2A2D_0AC, 28'h2E30_0B1, 28'h3134_0B4, 28'h3538_0BC, \
	28'h393C_0C4, 28'h3D40_0CC, 28'h4144_0D0, 28'h4548_0D4, \
	28'h494A_0D9, 28'h4B4C_0F1, 28'h4D4D_100, 28'h4E4F_109, \
	28'h5051_0E0, 28'h5255_0E4, 28'h5657_0E0, 28'h585B_0E4, \
	28'h5C5D_0E0, 28'h5E61_0E4, 28'h6263_0E0, 28'h6467_0E4, \
	28'h797B_079, 28'h7E7E_086, 28'h7F82_088, 28'h8386_08C, \
	28'h878A_094, 28'h8B8E_0B4, 28'h8F91_0B8, 28'h9393_0C0, \
	28'h9596_0C2, 28'h9798_0C8, 28'h999A_03C, 28'h9B9E_0DC, \
	28'h9FA2_0F4, 28'hA3A6_0F8, 28'hA7A8_0FC, 28'hAAAB_07C, \
	28'hACAD_310, 28'hAEAF_312, 28'hB0B3_004, 28'hB4B6_00C, \
	28'hB8BB_018, 28'hBCBF_01C, 28'hC0C3_020, 28'hC4C7_024, \
	28'hC8CB_028, 28'hCCCF_02C, 28'hD0D3_030, 28'hD6D7_03E }

// ----------------------------------------------------------------
// Software registers
// ----------------------------------------------------------------
`define AL_REG_CTRL       12'h000
`define AL_REG_STATUS     12'h004
`define AL_REG_COUNT      12'h008
`define AL_CTRL_HOLD      0
`define AL_CTRL_RELOAD    1
`define AL_ST_BUSY        0
`define AL_ST_DONE        1
`define AL_ST_SIGFAIL     2
`define AL_ST_NACK        3
`define AL_ST_STRAP       4
`define AL_ST_WP          5
`define AL_ST_REGION      11:8
`define AL_ST_ADDR        23:16
`define AL_ST_W1C_MASK    32'h0000_001E

`endif

// ===== src/eeprom_autoload_pkg.sv
/*
 * Types of the configuration autoloader: loader states, bus carriers and
 * the loader's state record.
 * Assumes the constants header sits beside it.
 */
package eeprom_autoload_pkg;
	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_START = 3'b001,
		S_SEND  = 3'b010,
		S_READ  = 3'b011,
		S_STOP  = 3'b100
	} fsm_e;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_s;

	typedef struct packed {
		logic        valid;
		logic [11:0] addr;
		logic [7:0]  data;
	} cfg_wr_s;

	typedef struct packed {
		fsm_e        fsm;
		logic [1:0]  q;
		logic [9:0]  qdiv;
		logic [3:0]  bitn;
		logic [7:0]  sh;
		logic [1:0]  seq;
		logic [7:0]  ee_addr;
		logic [7:0]  sig_lo;
		logic [3:0]  region;
		logic        misc_wp;
		logic        isa_wp;
		logic        last;
		logic        scl;
		logic        sda_oe;
		cfg_wr_s     cfg;
		logic        done;
		logic        sig_fail;
		logic        nack_err;
		logic        strap_block;
		logic        pend;
		logic        hold;
		logic [1:0]  settle;
		logic [8:0]  wcount;
		logic [31:0] prdata;
		logic [1:0]  sy_sth;
		logic [1:0]  sy_stl;
		logic [1:0]  sy_sda;
		logic [1:0]  sy_tr;
	} state_s;
endpackage

// ===== src/eeprom_config_autoload.sv
/*
 * Configuration autoloader: after reset it reads the serial EEPROM over
 * the two-wire bus and streams mapped bytes into configuration space as
 * one-cycle write strobes; APB exposes control and status.
 * Assumes an open-drain SDA wire resolved outside, a pulled-up bus, an
 * EEPROM with a one-byte word address, and a config space that accepts
 * one byte write per strobe.
 */
// Overview of operation
// - Proceed only when first word matches signature
// - Region 0000 stops after byte 0Bh
// - Region 0001 stops after byte 67h
// - Region 0111 loads through byte D7h
// - Misc bit0 write-protects bridge control bit2 in transparent mode only
// - Bytes 09h-0Bh load class code
// - Bytes 0D-0Eh load prefetch control 40h
// - Bytes 22-25h load clock control A4h
// - Bytes 1Bh,4E-4Fh load error mask 108h
// - Byte 4Dh loads error capability 100h
// - Four address/data pairs through E0h/E4h window
// - Bytes 79-7Bh load GPIO register 79h
// - Bytes 87-8Ah load power management 94h
// - Bytes B4-B6h load offsets 0C-0Eh
// - Bytes B8-BBh load bus numbers 18h
// - Bytes BC-BFh load I/O base 1Ch
// - Bytes C8-CBh load prefetch base upper
// - Bytes CC-CFh load prefetch limit upper
// - Bytes D0-D3h load I/O upper 30h
// - Bytes 3D-40h load transceiver tuning CCh
// - Two-wire load only with both straps low
`timescale 1ns/1ps
`include "eeprom_autoload_params.svh"

module eeprom_config_autoload #(
	parameter logic [7:0] GROUP3_STOP   = `AL_STOP_G3_DEF,
	parameter int         SCL_PERIOD_NS = `AL_SCL_PERIOD_NS
) (
	// Clock and reset
	input  wire logic                         REF_CLK,
	input  wire logic                         SYS_RST,
	// Register bus
	input  wire eeprom_autoload_pkg::apb_req_s APB_REQ,
	output      eeprom_autoload_pkg::apb_rsp_s APB_RSP,
	// Two-wire EEPROM link
	output      logic                         SCL,
	input  wire logic                         SDA_I,
	output      logic                         SDA_O,
	output      logic                         SDA_OE,
	// Straps and mode
	input  wire logic                         TEST_STRAP_HIGH,
	input  wire logic                         TEST_STRAP_LOW,
	input  wire logic                         TRANSPARENT_MODE,
	// Configuration space side
	output      eeprom_autoload_pkg::cfg_wr_s  CFG_WR,
	output      logic                         ISA_EN_WP,
	output      logic                         LOAD_BUSY
);
	import eeprom_autoload_pkg::*;

	// ----------------------------------------------------------------
	// Derived timing
	// ----------------------------------------------------------------
	localparam int         QUARTER_CYC = SCL_PERIOD_NS / (`AL_QUARTERS * `AL_CLK_PERIOD_NS);
	localparam logic [9:0] QDIV_RELOAD = 10'(QUARTER_CYC - 1);
	localparam logic [27:0] MAP [`AL_MAP_N] = `AL_MAP_TABLE;

	state_s      s;
	state_s      next_s;
	logic        tick;
	logic [7:0]  stop_addr;
	logic        map_hit;
	logic [11:0] map_off;
	logic [31:0] rd_data;
	logic        rd_known;
	logic        apb_wr;
	logic [`AL_MAP_N-1:0] hit;
	logic [11:0] acc [`AL_MAP_N+1];

	// ----------------------------------------------------------------
	// Byte map lookup
	// ----------------------------------------------------------------
	// Ranges are disjoint, so the offsets may simply be ORed together.
	assign acc[0] = 12'h000;
	for (genvar i = 0; i < `AL_MAP_N; i++) begin : g_map
		logic [7:0] delta;
		assign delta  = s.ee_addr - MAP[i][`AL_MAP_LO];
		assign hit[i] = (s.ee_addr >= MAP[i][`AL_MAP_LO]) &&
		                (s.ee_addr <= MAP[i][`AL_MAP_HI]);
		// Table rows
		// Table rows
		assign acc[i+1] = acc[i] |
		                  (hit[i] ? MAP[i][`AL_MAP_CFG] + {4'h0, delta} : 12'h000);
	end
	assign map_hit = |hit;
	assign map_off = acc[`AL_MAP_N];

	// ----------------------------------------------------------------
	// Stop offset
	// ----------------------------------------------------------------
	always_comb begin
		case (s.region)
			`AL_REGION_G1: stop_addr = `AL_STOP_G1;
			`AL_REGION_G2: stop_addr = `AL_STOP_G2;
			`AL_REGION_G3: stop_addr = GROUP3_STOP;
			`AL_REGION_G4: stop_addr = `AL_STOP_G4;
			// Undefined codes take the shortest load
			default:       stop_addr = `AL_STOP_G1;
		endcase
	end

	// ----------------------------------------------------------------
	// Register read mux
	// ----------------------------------------------------------------
	always_comb begin
		rd_data  = 32'h0000_0000;
		rd_known = 1'b1;
		case (APB_REQ.paddr)
			`AL_REG_CTRL: begin
				rd_data[`AL_CTRL_HOLD] = s.hold;
			end
			`AL_REG_STATUS: begin
				rd_data[`AL_ST_BUSY]    = (s.fsm != S_IDLE);
				rd_data[`AL_ST_DONE]    = s.done;
				rd_data[`AL_ST_SIGFAIL] = s.sig_fail;
				rd_data[`AL_ST_NACK]    = s.nack_err;
				rd_data[`AL_ST_STRAP]   = s.strap_block;
				rd_data[`AL_ST_WP]      = s.isa_wp;
				rd_data[`AL_ST_REGION]  = s.region;
				rd_data[`AL_ST_ADDR]    = s.ee_addr;
			end
			`AL_REG_COUNT: begin
				rd_data[8:0] = s.wcount;
			end
			default: begin
				rd_known = 1'b0;
			end
		endcase
	end

	assign apb_wr = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite && rd_known;
	assign tick   = (s.qdiv == 10'h000);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s           = s;
		next_s.cfg.valid = 1'b0;
		next_s.sy_sth    = {s.sy_sth[0], TEST_STRAP_HIGH};
		next_s.sy_stl    = {s.sy_stl[0], TEST_STRAP_LOW};
		next_s.sy_sda    = {s.sy_sda[0], SDA_I};
		next_s.sy_tr     = {s.sy_tr[0], TRANSPARENT_MODE};
		next_s.isa_wp    = s.misc_wp & s.sy_tr[1];
		next_s.qdiv      = tick ? QDIV_RELOAD : s.qdiv - 10'h001;
		if (s.settle != 2'b11) begin
			next_s.settle = s.settle + 2'b01;
		end

		// Register bus; read data is captured in the setup cycle
		if (APB_REQ.psel && !APB_REQ.penable) begin
			next_s.prdata = rd_data;
		end
		if (apb_wr && APB_REQ.paddr == `AL_REG_CTRL) begin
			next_s.hold = APB_REQ.pwdata[`AL_CTRL_HOLD];
			if (APB_REQ.pwdata[`AL_CTRL_RELOAD] && s.fsm == S_IDLE) begin
				next_s.pend = 1'b1;
			end
		end
		// Sticky flags clear on write-one; a set below still wins
		if (apb_wr && APB_REQ.paddr == `AL_REG_STATUS) begin
			if (APB_REQ.pwdata[`AL_ST_DONE]) begin
				next_s.done = 1'b0;
			end
			if (APB_REQ.pwdata[`AL_ST_SIGFAIL]) begin
				next_s.sig_fail = 1'b0;
			end
			if (APB_REQ.pwdata[`AL_ST_NACK]) begin
				next_s.nack_err = 1'b0;
			end
			if (APB_REQ.pwdata[`AL_ST_STRAP]) begin
				next_s.strap_block = 1'b0;
			end
		end

		// Loader; every bit is four quarters of the serial clock
		if (s.fsm != S_IDLE && tick) begin
			next_s.q = s.q + 2'b01;
		end
		case (s.fsm)
			S_IDLE: begin
				next_s.scl    = 1'b1;
				next_s.sda_oe = 1'b0;
				next_s.q      = 2'b00;
				// Straps are only trusted once their synchronisers have filled
				if (s.pend && !s.hold && s.settle == 2'b11) begin
					next_s.pend = 1'b0;
					if (s.sy_sth[1] || s.sy_stl[1]) begin
						next_s.strap_block = 1'b1;
					end else begin
						next_s.fsm     = S_START;
						next_s.qdiv    = QDIV_RELOAD;
						next_s.seq     = 2'b00;
						next_s.ee_addr = `AL_EE_FIRST;
						next_s.region  = `AL_REGION_G1;
						next_s.misc_wp = 1'b0;
						next_s.wcount  = 9'h000;
						next_s.last    = 1'b0;
					end
				end
			end
			S_START: begin
				if (tick) begin
					case (s.q)
						2'b00: begin
							next_s.scl    = 1'b0;
							next_s.sda_oe = 1'b0;
						end
						2'b01: begin
							next_s.scl = 1'b1;
						end
						2'b10: begin
							next_s.sda_oe = 1'b1;
						end
						default: begin
							next_s.scl  = 1'b0;
							next_s.fsm  = S_SEND;
							next_s.bitn = 4'h0;
							next_s.sh   = (s.seq == 2'b10) ? `AL_EE_DEV_RD : `AL_EE_DEV_WR;
						end
					endcase
				end
			end
			S_SEND: begin
				if (tick) begin
					case (s.q)
						2'b00: begin
							next_s.scl    = 1'b0;
							next_s.sda_oe = s.bitn[3] ? 1'b0 : ~s.sh[7];
						end
						2'b01: begin
							next_s.scl = 1'b1;
						end
						2'b10: begin
							if (s.bitn[3]) begin
								next_s.last = s.sy_sda[1];
							end
						end
						default: begin
							next_s.scl = 1'b0;
							if (!s.bitn[3]) begin
								next_s.sh   = {s.sh[6:0], 1'b0};
								next_s.bitn = s.bitn + 4'h1;
							end else if (s.last) begin
								next_s.nack_err = 1'b1;
								next_s.fsm      = S_STOP;
							end else begin
								case (s.seq)
									2'b00: begin
										next_s.seq  = 2'b01;
										next_s.sh   = `AL_EE_FIRST;
										next_s.bitn = 4'h0;
									end
									2'b01: begin
										next_s.seq = 2'b10;
										next_s.fsm = S_START;
									end
									default: begin
										next_s.fsm  = S_READ;
										next_s.bitn = 4'h0;
										next_s.last = 1'b0;
									end
								endcase
							end
						end
					endcase
				end
			end
			S_READ: begin
				if (tick) begin
					case (s.q)
						2'b00: begin
							next_s.scl    = 1'b0;
							// Acknowledge every byte but the last
							next_s.sda_oe = s.bitn[3] ? ~s.last : 1'b0;
						end
						2'b01: begin
							next_s.scl = 1'b1;
						end
						2'b10: begin
							if (!s.bitn[3]) begin
								next_s.sh = {s.sh[6:0], s.sy_sda[1]};
							end
						end
						default: begin
							next_s.scl = 1'b0;
							if (!s.bitn[3]) begin
								next_s.bitn = s.bitn + 4'h1;
							end else if (s.last) begin
								next_s.fsm = S_STOP;
							end else begin
								next_s.ee_addr = s.ee_addr + 8'h01;
								next_s.bitn    = 4'h0;
							end
							// Byte complete: act on it before its acknowledge bit
							if (s.bitn == 4'h7) begin
								next_s.last = (s.ee_addr == stop_addr) ||
								              (s.ee_addr == `AL_EE_LAST);
								case (s.ee_addr)
									`AL_SIG_LO_ADDR: begin
										next_s.sig_lo = s.sh;
									end
									`AL_SIG_HI_ADDR: begin
										if ({s.sh, s.sig_lo} != `AL_SIGNATURE) begin
											next_s.sig_fail = 1'b1;
											next_s.last     = 1'b1;
										end
									end
									`AL_REGION_ADDR: begin
										next_s.region = s.sh[`AL_REGION_FIELD];
									end
									`AL_MISC_ADDR: begin
										next_s.misc_wp = s.sh[`AL_MISC_WP_BIT];
									end
									default: begin
										// Window pairs land in order as addresses rise
										if (map_hit) begin
											next_s.cfg.valid = 1'b1;
											next_s.cfg.addr  = map_off;
											next_s.cfg.data  = s.sh;
											next_s.wcount    = s.wcount + 9'h001;
										end
									end
								endcase
							end
						end
					endcase
				end
			end
			S_STOP: begin
				if (tick) begin
					case (s.q)
						2'b00: begin
							next_s.scl    = 1'b0;
							next_s.sda_oe = 1'b1;
						end
						2'b01: begin
							next_s.scl = 1'b1;
						end
						2'b10: begin
							next_s.sda_oe = 1'b0;
						end
						default: begin
							next_s.fsm  = S_IDLE;
							next_s.done = 1'b1;
						end
					endcase
				end
			end
			default: begin
				next_s.fsm = S_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			s        <= '0;
			s.fsm    <= S_IDLE;
			s.scl    <= 1'b1;
			s.pend   <= 1'b1;
			s.region <= `AL_REGION_G1;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign APB_RSP.prdata  = s.prdata;
	assign APB_RSP.pready  = 1'b1;
	assign APB_RSP.pslverr = APB_REQ.psel && APB_REQ.penable && !rd_known;
	assign SCL             = s.scl;
	assign SDA_O           = 1'b0;
	assign SDA_OE          = s.sda_oe;
	assign CFG_WR          = s.cfg;
	assign ISA_EN_WP       = s.isa_wp;
	assign LOAD_BUSY       = (s.fsm != S_IDLE) || s.pend;
endmodule

// ===== verification/eeprom_config_autoload_chk.sv
/*
 * Port checker of the configuration autoloader.
 * Assumes binding to the loader top; sees its ports only.
 */
`timescale 1ns/1ps
module eeprom_config_autoload_chk (
	// Clock and reset
	input wire logic                          REF_CLK,
	input wire logic                          SYS_RST,
	// Register bus
	input wire eeprom_autoload_pkg::apb_req_s APB_REQ,
	input wire eeprom_autoload_pkg::apb_rsp_s APB_RSP,
	// Link and straps
	input wire logic                          SCL,
	input wire logic                          SDA_O,
	input wire logic                          SDA_OE,
	input wire logic                          TEST_STRAP_HIGH,
	input wire logic                          TEST_STRAP_LOW,
	input wire logic                          TRANSPARENT_MODE,
	// Config side
	input wire eeprom_autoload_pkg::cfg_wr_s  CFG_WR,
	input wire logic                          ISA_EN_WP,
	input wire logic                          LOAD_BUSY
);
	import eeprom_autoload_pkg::*;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);

	// ----
	// Sequences
	// ----
	// A byte takes far longer than eight cycles even at the fast bit rate
	sequence s_gap;
		!CFG_WR.valid [*8];
	endsequence
	sequence s_quiet;
		!SDA_OE throughout (##[1:8] !LOAD_BUSY);
	endsequence

	// ----
	// Assertions
	// ----
	AST_CFG_PULSE: assert property (CFG_WR.valid |=> s_gap)
		else $error("config strobe too long or too close");
	AST_CFG_BUSY: assert property (CFG_WR.valid |-> LOAD_BUSY)
		else $error("config strobe outside a load");
	AST_LINK_IDLE: assert property (!LOAD_BUSY |-> SCL && !SDA_OE)
		else $error("link active while idle");
	AST_STRAP_BLOCK: assert property ($fell(SYS_RST) && (TEST_STRAP_HIGH || TEST_STRAP_LOW)
		|-> s_quiet)
		else $error("load not blocked by straps");
	AST_ISA_OFF: assert property (!TRANSPARENT_MODE [*6] |-> !ISA_EN_WP)
		else $error("protect outside transparent mode");
	AST_RST_STATE: assert property ($fell(SYS_RST)
		|-> SCL && !SDA_OE && !CFG_WR.valid && !ISA_EN_WP && LOAD_BUSY)
		else $error("bad state after reset");
	AST_APB_RSP: assert property (APB_REQ.psel && APB_REQ.penable |-> APB_RSP.pready
		&& (APB_RSP.pslverr == !(APB_REQ.paddr inside {12'h000, 12'h004, 12'h008})))
		else $error("bad bus response");
	AST_OPEN_DRAIN: assert property (SDA_OE |-> !SDA_O && LOAD_BUSY)
		else $error("data line driven high");
endmodule

bind eeprom_config_autoload eeprom_config_autoload_chk u_eeprom_config_autoload_chk (
	.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP),
	.SCL(SCL), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .TEST_STRAP_HIGH(TEST_STRAP_HIGH),
	.TEST_STRAP_LOW(TEST_STRAP_LOW), .TRANSPARENT_MODE(TRANSPARENT_MODE),
	.CFG_WR(CFG_WR), .ISA_EN_WP(ISA_EN_WP), .LOAD_BUSY(LOAD_BUSY));

// ===== verification/eeprom_config_autoload_test.sv
/*
 * Self-checking bench of the configuration autoloader.
 * Assumes the EEPROM model and the bound checker; data byte equals its address.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin \
	n_compared++; \
	if ((a) !== (b)) begin \
		failures++; \
		$display("ERROR %0t: got %0h want %0h", $time, (a), (b)); \
	end \
end
module eeprom_config_autoload_test;
	import eeprom_autoload_pkg::*;
	localparam logic [7:0] G3_STOP = 8'h0F;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	apb_req_s    req = '0;
	apb_rsp_s    rsp;
	logic        scl, sda_o, sda_oe, pull, isa_wp, busy;
	logic        hi = 1'b0;
	logic        lo = 1'b0;
	logic        tm = 1'b0;
	logic        nak = 1'b0;
	cfg_wr_s     cfg;
	wire         sda = !((sda_oe && !sda_o) || pull);
	int          failures = 0;
	int          n_compared = 0;
	int          nw = 0;
	logic [11:0] wa [256];
	bit          seen [256];
	logic [7:0]  last;
	logic [31:0] rd;
	logic        err;
	logic [27:0] map [24] = '{28'h0909_009, 28'h0A0B_00A, 28'h0D0E_040,
		28'h1B1B_108, 28'h4E4F_109, 28'h2225_0A4, 28'h3D40_0CC,
		28'h4D4D_100, 28'h5051_0E0, 28'h5255_0E4, 28'h5657_0E0,
		28'h585B_0E4, 28'h5C5D_0E0, 28'h5E61_0E4, 28'h6263_0E0,
		28'h6467_0E4, 28'h797B_079, 28'h878A_094, 28'hB4B6_00C,
		28'hB8BB_018, 28'hBCBF_01C, 28'hC8CB_028, 28'hCCCF_02C,
		28'hD0D3_030};

	eeprom_config_autoload #(.GROUP3_STOP(G3_STOP), .SCL_PERIOD_NS(400)) u_eeprom_config_autoload (
		.REF_CLK(clk), .SYS_RST(rst), .APB_REQ(req), .APB_RSP(rsp), .SCL(scl), .SDA_I(sda),
		.SDA_O(sda_o), .SDA_OE(sda_oe), .TEST_STRAP_HIGH(hi), .TEST_STRAP_LOW(lo),
		.TRANSPARENT_MODE(tm), .CFG_WR(cfg), .ISA_EN_WP(isa_wp), .LOAD_BUSY(busy));
	eeprom_model u_eeprom_model (.scl(scl), .sda(sda), .pull(pull), .nak(nak));

	always #10 clk = !clk;

	always @(posedge clk) if (cfg.valid === 1'b1) begin
		`CHK(nw == 0 || cfg.data > last, 1'b1)
		wa[cfg.data] = cfg.addr;
		seen[cfg.data] = 1'b1;
		last = cfg.data;
		nw++;
	end

	// ----
	// Helpers
	// ----
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk);
		req.penable <= 1'b1;
		@(posedge clk);
		// No wait-state count is assumed; only the watchdog ends a hung access
		while (rsp.pready !== 1'b1) @(posedge clk);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
	endtask
	task reset;
		rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
	endtask
	task wait_idle;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 60000 && busy !== 1'b0; i++) @(posedge clk);
	endtask
	task setup(input logic [3:0] region, input logic misc, input logic [7:0] sig_hi);
		for (int i = 0; i < 256; i++) begin
			u_eeprom_model.mem[i] = i[7:0];
			seen[i] = 1'b0;
			// Stale targets from an earlier load must not satisfy the map check
			wa[i] = 12'hFFF;
		end
		u_eeprom_model.mem[0] = 8'h16;
		u_eeprom_model.mem[1] = sig_hi;
		u_eeprom_model.mem[2] = {3'h0, region, 1'b0};
		u_eeprom_model.mem[3] = {7'h00, misc};
		nw = 0;
	endtask
	task check_map(input logic [7:0] stop);
		for (int k = 0; k < 24; k++)
			if (map[k][19:12] <= stop)
				for (int j = map[k][27:20]; j <= map[k][19:12]; j++)
					`CHK(wa[j], map[k][11:0] + 12'(j - map[k][27:20]))
		for (int j = 0; j < 256; j++)
			if (j > stop || j < 4 || j inside {[8'h68:8'h77], 8'h7C, 8'h7D, 8'h92, 8'h94,
				8'hA9, 8'hB7, 8'hD4, 8'hD5, 8'h78})
				`CHK(seen[j], 1'b0)
		`CHK(seen[stop], 1'b1)
	endtask
	task run_load(input logic [3:0] region, input logic [7:0] stop, input logic misc);
		setup(region, misc, 8'h15);
		apb(1'b1, 12'h000, 32'h2);
		wait_idle();
		check_map(stop);
		apb(1'b0, 12'h004, 32'h0);
		`CHK(rd[11:8], region)
		`CHK(rd[5], misc & tm)
		`CHK(isa_wp, misc & tm)
	endtask

	// ----
	// Scenarios
	// ----
	task t_auto;
		wait_idle();
		check_map(8'h0B);
		`CHK(isa_wp, 1'b0)
		apb(1'b0, 12'h008, 32'h0);
		`CHK(rd[8:0], 9'h008)
		apb(1'b0, 12'h004, 32'h0);
		`CHK(rd[3:1], 3'h1)
		apb(1'b1, 12'h004, 32'h0000_001E);
		apb(1'b0, 12'h004, 32'h0);
		`CHK(rd[1], 1'b0)
	endtask
	task t_regs;
		apb(1'b0, 12'h00C, 32'h0);
		`CHK(err, 1'b1)
		`CHK(rd, 32'h0)
		apb(1'b1, 12'h000, 32'h1);
		apb(1'b0, 12'h000, 32'h0);
		`CHK(rd, 32'h1)
		apb(1'b1, 12'h000, 32'h0);
	endtask
	task t_sig;
		setup(4'h7, 1'b0, 8'h14);
		apb(1'b1, 12'h000, 32'h2);
		wait_idle();
		`CHK(nw, 0)
		apb(1'b0, 12'h004, 32'h0);
		`CHK(rd[2], 1'b1)
	endtask
	task t_nack;
		nak <= 1'b1;
		setup(4'h0, 1'b0, 8'h15);
		apb(1'b1, 12'h000, 32'h2);
		wait_idle();
		nak <= 1'b0;
		`CHK(nw, 0)
		apb(1'b0, 12'h004, 32'h0);
		`CHK(rd[3], 1'b1)
	endtask
	task t_regions;
		tm <= 1'b1;
		run_load(4'h3, G3_STOP, 1'b0);
		run_load(4'h1, 8'h67, 1'b0);
		run_load(4'h7, 8'hD7, 1'b1);
		run_load(4'h5, 8'h0B, 1'b0);
	endtask
	task t_strap;
		for (int s = 1; s < 3; s++) begin
			hi <= s[0];
			lo <= s[1];
			nw = 0;
			reset();
			wait_idle();
			`CHK(nw, 0)
			`CHK(busy, 1'b0)
			apb(1'b0, 12'h004, 32'h0);
			`CHK(rd[4], 1'b1)
		end
	endtask

	task complete_run;
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		setup(4'h0, 1'b1, 8'h15);
		reset();
		t_auto();
		t_regs();
		t_sig();
		t_nack();
		t_regions();
		t_strap();
		complete_run();
	end
	// Whole run is near 70k cycles at the fast bit rate
	initial begin
		repeat (95000) @(posedge clk);
		failures++;
		complete_run();
	end
endmodule

// ===== verification/eeprom_model.sv
/*
 * Behavioural two-wire EEPROM, 256 bytes, one-byte word address.
 * Assumes a pulled-up data wire resolved outside; pull high drives it low.
 */
`timescale 1ns/1ps
module eeprom_model (
	// Two-wire pins
	input  wire logic scl,
	input  wire logic sda,
	output logic      pull,
	// Fault control
	input  wire logic nak
);
	logic [7:0] mem [256];
	logic [7:0] ptr;
	logic [7:0] sh;
	logic       ack;
	int         st;
	int         n;

	initial begin
		pull = 1'b0;
	end
	// Start and stop: data edges while clock is high
	always @(negedge sda) if (scl) begin
		st = 1;
		n = 0;
	end
	always @(posedge sda) if (scl) begin
		st = 0;
		pull = 1'b0;
	end
	always @(posedge scl) begin
		if (st == 1 || st == 2) begin
			if (n < 8) sh = {sh[6:0], sda};
		end else if (st == 3 && n == 8 && sda) begin
			st = 0;
		end
		n++;
	end
	// Data changes only while the clock is low
	always @(negedge scl) begin
		if (st == 3) begin
			if (n == 9) begin
				n = 0;
				ptr++;
			end
			pull = (n < 8) ? !mem[ptr][7-n] : 1'b0;
		end else if (st != 0 && n == 8) begin
			ack = !nak && (st == 2 || sh[7:1] == 7'h50);
			pull = ack;
		end else if (st != 0 && n == 9) begin
			n = 0;
			if (st == 2) ptr = sh;
			st = (st == 1 && ack) ? (sh[0] ? 3 : 2) : 0;
			pull = (st == 3) && !mem[ptr][7];
		end
	end
endmodule
